// ---- shared/tcpc_pkg.sv ----
// package for the timer capture and pwm control block
// assumes a classic wishbone slave with 32-bit data, 8-bit registers in the low lane
package tcpc_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_CTRL_TWO = 6'h17;
  localparam logic [5:0] IDX_CTRL_ONE = 6'h18;
  localparam logic [5:0] IDX_CAP2_LO = 6'h19;
  localparam logic [5:0] IDX_CAP2_HI = 6'h1a;
  localparam logic [5:0] IDX_SHARED_LO = 6'h1b;
  localparam logic [5:0] IDX_SHARED_HI = 6'h1c;
  localparam logic [5:0] IDX_T3_LO = 6'h1d;
  localparam logic [5:0] IDX_T3_HI = 6'h1e;
  localparam logic [5:0] IDX_T1 = 6'h1f;
  localparam logic [5:0] IDX_T2 = 6'h20;
  localparam logic [5:0] IDX_PER1 = 6'h21;
  localparam logic [5:0] IDX_PER2 = 6'h22;
  localparam logic [5:0] IDX_IRQ_STAT = 6'h23;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h24;

  // field positions of the control register two
  localparam int CAP2_OVF_BIT = 7;
  localparam int CAP1_OVF_BIT = 6;
  localparam int WRITABLE_MSB = 5;
  // field position of the control register one
  localparam int COMBINED_BIT = 0;

  // interrupt status bit positions
  localparam int EV_CAP1 = 0;
  localparam int EV_CAP2 = 1;
  localparam int EV_OVF1 = 2;
  localparam int EV_OVF2 = 3;
  localparam int EV_T1_WRAP = 4;
  localparam int EV_T2_WRAP = 5;
  localparam int EV_T3_WRAP = 6;
  localparam int EV_COUNT = 7;

  // reset values
  localparam logic [5:0] CTRL_TWO_RESET = 6'h00;
  localparam logic [7:0] PERIOD_RESET = 8'hff;
  localparam logic [15:0] SHARED_RESET = 16'hffff;
  localparam logic [6:0] IRQ_MASK_RESET = 7'h00;

  // timing: system clocks per timer increment
  localparam int TICK_DIV_DEFAULT = 4;

  // writable part of control register two, bit 5 down to bit 0
  typedef struct packed {
    logic second_pwm_enable;
    logic first_pwm_enable;
    logic capture_or_period_select;
    logic timer_three_run;
    logic timer_two_run;
    logic timer_one_run;
  } tcpc_ctrl_t;

endpackage

// ---- rtl/tcpc_top.sv ----
// timer capture and pwm control: control register two with its timers, captures and pin steering
// assumes a classic wishbone master on clk_i; capture inputs are asynchronous pins
// What this block does
// - capture two sets overflow bit 7 when an event meets an unread value
// - on overflow the capture pair keeps the oldest unread value
// - after overflow, captures stay blocked until both bytes are read
// - capture one behaves alike on the shared pair, reported in bit 6
// - second pwm enable drives its pin, else port direction bit rules
// - first pwm enable drives its pin, else port direction bit rules
// - mode select one: shared pair captures, timer three free runs; zero: period
// - timer two run bit gates timer two, also the upper byte when combined
// - timer one run bit starts the combined counter or timer one alone
// - combined mode chains timer two and one into one 16-bit counter
// - every capture latches the timer three count
`timescale 1ns/1ps
`default_nettype none

module tcpc_top #(
  parameter int TICK_DIV = tcpc_pkg::TICK_DIV_DEFAULT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic capture_one_pin_i,
  input wire logic capture_two_pin_i,
  input wire logic first_pwm_level_i,
  input wire logic second_pwm_level_i,
  input wire logic first_port_data_i,
  input wire logic second_port_data_i,
  input wire logic first_port_b_direction_i,
  input wire logic second_port_b_direction_i,
  output logic first_pwm_pin_o,
  output logic first_pwm_pin_oe_o,
  output logic second_pwm_pin_o,
  output logic second_pwm_pin_oe_o,
  output logic irq_o
);

  localparam int TW = $clog2(TICK_DIV);

  if (TICK_DIV < 2)
  begin : g_check
    $error("TICK_DIV must be at least 2");
  end

  // state
  tcpc_pkg::tcpc_ctrl_t ctrl_r, ctrl_nxt;
  logic combined_r, combined_nxt;
  logic [7:0] t1_r, t1_nxt, t2_r, t2_nxt, per1_r, per1_nxt, per2_r, per2_nxt;
  logic [15:0] t3_r, t3_nxt;
  logic [15:0] cap_r [2];
  logic [15:0] cap_nxt [2];
  logic [1:0] pend_r, pend_nxt, ovf_r, ovf_nxt, lo_seen_r, lo_seen_nxt, hi_seen_r, hi_seen_nxt;
  logic [1:0] sync1_r, sync2_r, prev_r;
  logic [TW-1:0] tick_cnt_r, tick_cnt_nxt;
  logic tick_r, tick_nxt;
  logic [6:0] stat_r, stat_nxt, mask_r, mask_nxt;
  logic ack_r, ack_nxt, irq_r, irq_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic p1_r, p1_oe_r, p2_r, p2_oe_r, p1_nxt, p1_oe_nxt, p2_nxt, p2_oe_nxt;

  // bus decode
  logic req, wr, rd;
  logic [5:0] idx;
  logic [7:0] wd;
  logic [1:0] cap_evt, rd_lo, rd_hi, done;
  logic w1, w2, w3;
  logic [6:0] events;

  assign req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign rd = req & ~wb_we_i;
  assign idx = wb_adr_i[7:2];
  assign wd = wb_dat_i[7:0];

  // capture pin edges after two flip-flops
  assign cap_evt = sync2_r & ~prev_r;
  assign rd_lo = {rd && idx == tcpc_pkg::IDX_CAP2_LO, rd && idx == tcpc_pkg::IDX_SHARED_LO};
  assign rd_hi = {rd && idx == tcpc_pkg::IDX_CAP2_HI, rd && idx == tcpc_pkg::IDX_SHARED_HI};
  assign done = pend_r & (rd_lo | lo_seen_r) & (rd_hi | hi_seen_r);

  // timer increment enable from a divider
  always_comb
  begin
    tick_cnt_nxt = tick_cnt_r + TW'(1);
    tick_nxt = 1'b0;
    if (tick_cnt_r == TW'(TICK_DIV - 1))
    begin
      tick_cnt_nxt = '0;
      tick_nxt = 1'b1;
    end
  end

  // capture channels: 0 is capture one on the shared pair, 1 is capture two
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      cap_nxt[i] = cap_r[i];
      pend_nxt[i] = pend_r[i];
      ovf_nxt[i] = ovf_r[i];
      lo_seen_nxt[i] = lo_seen_r[i] | rd_lo[i];
      hi_seen_nxt[i] = hi_seen_r[i] | rd_hi[i];
      if (done[i])
      begin
        pend_nxt[i] = 1'b0;
        ovf_nxt[i] = 1'b0;
        lo_seen_nxt[i] = 1'b0;
        hi_seen_nxt[i] = 1'b0;
      end
      if (cap_evt[i] && (i == 1 || ctrl_r.capture_or_period_select))
      begin
        if (pend_r[i] && !done[i])
        begin
          ovf_nxt[i] = 1'b1;
        end
        else
        begin
          cap_nxt[i] = t3_r;
          pend_nxt[i] = 1'b1;
          lo_seen_nxt[i] = 1'b0;
          hi_seen_nxt[i] = 1'b0;
        end
      end
    end
    // shared pair doubles as the timer three period
    if (wr && idx == tcpc_pkg::IDX_SHARED_LO)
    begin
      cap_nxt[0][7:0] = wd;
    end
    if (wr && idx == tcpc_pkg::IDX_SHARED_HI)
    begin
      cap_nxt[0][15:8] = wd;
    end
  end

  // timers one, two and three
  always_comb
  begin
    t1_nxt = t1_r;
    t2_nxt = t2_r;
    t3_nxt = t3_r;
    w1 = 1'b0;
    w2 = 1'b0;
    w3 = 1'b0;
    if (tick_r)
    begin
      if (combined_r)
      begin
        if (ctrl_r.timer_one_run)
        begin
          if ({t2_r, t1_r} == {per2_r, per1_r})
          begin
            t1_nxt = '0;
            t2_nxt = '0;
            w1 = 1'b1;
          end
          else
          begin
            t1_nxt = t1_r + 8'h01;
            if (t1_r == 8'hff && ctrl_r.timer_two_run)
            begin
              t2_nxt = t2_r + 8'h01;
            end
          end
        end
      end
      else
      begin
        if (ctrl_r.timer_one_run)
        begin
          w1 = t1_r == per1_r;
          t1_nxt = w1 ? 8'h00 : t1_r + 8'h01;
        end
        if (ctrl_r.timer_two_run)
        begin
          w2 = t2_r == per2_r;
          t2_nxt = w2 ? 8'h00 : t2_r + 8'h01;
        end
      end
      if (ctrl_r.timer_three_run)
      begin
        if (!ctrl_r.capture_or_period_select && t3_r == cap_r[0])
        begin
          t3_nxt = '0;
          w3 = 1'b1;
        end
        else
        begin
          t3_nxt = t3_r + 16'h0001;
          w3 = t3_r == 16'hffff;
        end
      end
    end
    if (wr && idx == tcpc_pkg::IDX_T1)
    begin
      t1_nxt = wd;
    end
    if (wr && idx == tcpc_pkg::IDX_T2)
    begin
      t2_nxt = wd;
    end
    if (wr && idx == tcpc_pkg::IDX_T3_LO)
    begin
      t3_nxt[7:0] = wd;
    end
    if (wr && idx == tcpc_pkg::IDX_T3_HI)
    begin
      t3_nxt[15:8] = wd;
    end
  end

  // register writes, interrupt flags and read data
  assign events = {w3, w2, w1, ovf_nxt & ~ovf_r, cap_evt & pend_nxt & ~pend_r};

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    combined_nxt = combined_r;
    per1_nxt = per1_r;
    per2_nxt = per2_r;
    mask_nxt = mask_r;
    stat_nxt = stat_r;
    dat_nxt = dat_r;
    if (wr)
    begin
      case (idx)
        tcpc_pkg::IDX_CTRL_TWO: ctrl_nxt = wd[tcpc_pkg::WRITABLE_MSB:0];
        tcpc_pkg::IDX_CTRL_ONE: combined_nxt = wd[tcpc_pkg::COMBINED_BIT];
        tcpc_pkg::IDX_PER1: per1_nxt = wd;
        tcpc_pkg::IDX_PER2: per2_nxt = wd;
        tcpc_pkg::IDX_IRQ_MASK: mask_nxt = wd[6:0];
        default: ;
      endcase
    end
    if (rd)
    begin
      dat_nxt = '0;
      case (idx)
        tcpc_pkg::IDX_CTRL_TWO: dat_nxt[7:0] = {ovf_r[1], ovf_r[0], ctrl_r};
        tcpc_pkg::IDX_CTRL_ONE: dat_nxt[tcpc_pkg::COMBINED_BIT] = combined_r;
        tcpc_pkg::IDX_CAP2_LO: dat_nxt[7:0] = cap_r[1][7:0];
        tcpc_pkg::IDX_CAP2_HI: dat_nxt[7:0] = cap_r[1][15:8];
        tcpc_pkg::IDX_SHARED_LO: dat_nxt[7:0] = cap_r[0][7:0];
        tcpc_pkg::IDX_SHARED_HI: dat_nxt[7:0] = cap_r[0][15:8];
        tcpc_pkg::IDX_T3_LO: dat_nxt[7:0] = t3_r[7:0];
        tcpc_pkg::IDX_T3_HI: dat_nxt[7:0] = t3_r[15:8];
        tcpc_pkg::IDX_T1: dat_nxt[7:0] = t1_r;
        tcpc_pkg::IDX_T2: dat_nxt[7:0] = t2_r;
        tcpc_pkg::IDX_PER1: dat_nxt[7:0] = per1_r;
        tcpc_pkg::IDX_PER2: dat_nxt[7:0] = per2_r;
        tcpc_pkg::IDX_IRQ_STAT: dat_nxt[6:0] = stat_r;
        tcpc_pkg::IDX_IRQ_MASK: dat_nxt[6:0] = mask_r;
        default: dat_nxt = '0; // unmapped reads zero
      endcase
      if (idx == tcpc_pkg::IDX_IRQ_STAT)
      begin
        stat_nxt = '0; // read clears
      end
    end
    stat_nxt = stat_nxt | events; // set wins over clear
    ack_nxt = req;
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  // pin steering between pwm and port direction
  always_comb
  begin
    p1_oe_nxt = ctrl_r.first_pwm_enable | ~first_port_b_direction_i;
    p1_nxt = ctrl_r.first_pwm_enable ? first_pwm_level_i : first_port_data_i;
    p2_oe_nxt = ctrl_r.second_pwm_enable | ~second_port_b_direction_i;
    p2_nxt = ctrl_r.second_pwm_enable ? second_pwm_level_i : second_port_data_i;
  end

  // state registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_r <= tcpc_pkg::CTRL_TWO_RESET;
      combined_r <= 1'b0;
      t1_r <= '0;
      t2_r <= '0;
      t3_r <= '0;
      per1_r <= tcpc_pkg::PERIOD_RESET;
      per2_r <= tcpc_pkg::PERIOD_RESET;
      cap_r[0] <= tcpc_pkg::SHARED_RESET;
      cap_r[1] <= '0;
      pend_r <= '0;
      ovf_r <= '0;
      lo_seen_r <= '0;
      hi_seen_r <= '0;
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
      stat_r <= '0;
      mask_r <= tcpc_pkg::IRQ_MASK_RESET;
      ack_r <= 1'b0;
      irq_r <= 1'b0;
      dat_r <= '0;
      p1_r <= 1'b0;
      p1_oe_r <= 1'b0;
      p2_r <= 1'b0;
      p2_oe_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      combined_r <= combined_nxt;
      t1_r <= t1_nxt;
      t2_r <= t2_nxt;
      t3_r <= t3_nxt;
      per1_r <= per1_nxt;
      per2_r <= per2_nxt;
      cap_r <= cap_nxt;
      pend_r <= pend_nxt;
      ovf_r <= ovf_nxt;
      lo_seen_r <= lo_seen_nxt;
      hi_seen_r <= hi_seen_nxt;
      sync1_r <= {capture_two_pin_i, capture_one_pin_i};
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
      tick_cnt_r <= tick_cnt_nxt;
      tick_r <= tick_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      ack_r <= ack_nxt;
      irq_r <= irq_nxt;
      dat_r <= dat_nxt;
      p1_r <= p1_nxt;
      p1_oe_r <= p1_oe_nxt;
      p2_r <= p2_nxt;
      p2_oe_r <= p2_oe_nxt;
    end
  end

  assign wb_dat_o = dat_r;
  assign wb_ack_o = ack_r;
  assign irq_o = irq_r;
  assign first_pwm_pin_o = p1_r;
  assign first_pwm_pin_oe_o = p1_oe_r;
  assign second_pwm_pin_o = p2_r;
  assign second_pwm_pin_oe_o = p2_oe_r;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_cap2_clash;
    pend_r[1] && cap_evt[1] && !done[1];
  endsequence

  sequence s_cap1_clash;
    pend_r[0] && cap_evt[0] && !done[0] && ctrl_r.capture_or_period_select;
  endsequence

  a_cap2_overflow_set: assert property (s_cap2_clash |=> ovf_r[1])
    else $error("capture two overflow not set");
  a_cap2_value_hold: assert property (s_cap2_clash ##0 !(wr && idx == tcpc_pkg::IDX_SHARED_LO)
    |=> cap_r[1] == $past(cap_r[1]))
    else $error("capture two value lost on overflow");
  a_cap_blocked: assert property (ovf_r[1] && !done[1] |=> $stable(cap_r[1]))
    else $error("capture loaded while overflow pending");
  a_cap1_overflow_set: assert property (s_cap1_clash |=> ovf_r[0] ##1 ($stable(cap_r[0]) || $past(wr)))
    else $error("capture one overflow not set");
  a_pwm2_oe_drive: assert property (ctrl_r.second_pwm_enable |=> second_pwm_pin_oe_o)
    else $error("second pwm pin not driven");
  a_pwm1_dir_follow: assert property (!ctrl_r.first_pwm_enable && first_port_b_direction_i
    |=> !first_pwm_pin_oe_o)
    else $error("first pwm pin ignores direction");
  a_t3_period_wrap: assert property (tick_r && ctrl_r.timer_three_run && !ctrl_r.capture_or_period_select
    && t3_r == cap_r[0] && !wr |=> t3_r == 16'h0000)
    else $error("timer three missed its period");
  a_t3_halt_hold: assert property (!ctrl_r.timer_three_run && !wr |=> $stable(t3_r))
    else $error("timer three moved while stopped");
  a_t2_upper_gate: assert property (combined_r && !ctrl_r.timer_two_run && !wr
    |=> $stable(t2_r) || ($past(w1) && t2_r == 8'h00))
    else $error("upper byte advanced without run bit");
  a_t1_halt_hold: assert property (!ctrl_r.timer_one_run && !wr |=> $stable(t1_r))
    else $error("timer one moved while stopped");
  a_chain_carry: assert property (tick_r && combined_r && ctrl_r.timer_one_run && ctrl_r.timer_two_run
    && t1_r == 8'hff && {t2_r, t1_r} != {per2_r, per1_r} && !wr |=> t2_r == $past(t2_r) + 8'h01)
    else $error("combined counter carry lost");
  a_cap_source: assert property (cap_evt[1] && !pend_r[1] |=> cap_r[1] == $past(t3_r))
    else $error("capture did not take timer three");
  a_ovf_cause: assert property ($rose(ovf_r[1]) |-> $past(cap_evt[1]))
    else $error("overflow set without capture");

endmodule

`default_nettype wire

// ---- test/tb_tcpc_top.sv ----
// self-checking bench for the timer capture and pwm control block
// assumes tcpc_pkg is compiled first; the bench is the wishbone master and drives every pin itself
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end

module tb_tcpc_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic cap1 = 1'b0;
  logic cap2 = 1'b0;
  logic pwm1 = 1'b0;
  logic pwm2 = 1'b0;
  logic pd1 = 1'b0;
  logic pd2 = 1'b0;
  logic dir1 = 1'b1;
  logic dir2 = 1'b1;
  logic p1, p1oe, p2, p2oe, irq_o;
  logic [31:0] rd;
  int num_errors = 0;
  int checks_done = 0;

  // design with a short timer tick so counts stay quick
  tcpc_top #(.TICK_DIV(2)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .capture_one_pin_i(cap1), .capture_two_pin_i(cap2), .first_pwm_level_i(pwm1),
    .second_pwm_level_i(pwm2), .first_port_data_i(pd1), .second_port_data_i(pd2),
    .first_port_b_direction_i(dir1), .second_port_b_direction_i(dir2), .first_pwm_pin_o(p1),
    .first_pwm_pin_oe_o(p1oe), .second_pwm_pin_o(p2), .second_pwm_pin_oe_o(p2oe), .irq_o(irq_o)
  );

  // 40 MHz clock
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end

  // verdict and end of run
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one classic wishbone cycle, held until ack is sampled high
  task automatic wb_xfer(input logic we, input logic [5:0] idx, input logic [7:0] d, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, d};
    // wait for ack as long as it takes; the watchdog ends a hang
    do
    begin
      @(posedge clk_i);
    end
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    wb_xfer(1'b1, idx, d, rd);
  endtask

  task automatic rdc(input logic [5:0] idx, input logic [7:0] e);
    wb_xfer(1'b0, idx, 8'h00, rd);
    `CHK(rd, {24'h0, e})
  endtask

  // rising edge on a capture pin, then time for sync and load
  task automatic pulse(input logic two);
    @(posedge clk_i);
    if (two)
      cap2 <= 1'b1;
    else
      cap1 <= 1'b1;
    repeat (3) @(posedge clk_i);
    cap1 <= 1'b0;
    cap2 <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask

  // preload timer one and two, run a few ticks, expect the upper count
  task automatic tmr(input logic comb, input logic [7:0] run, input logic [7:0] e);
    wr(tcpc_pkg::IDX_CTRL_TWO, 8'h00);
    wr(tcpc_pkg::IDX_CTRL_ONE, {7'h0, comb});
    wr(tcpc_pkg::IDX_T1, 8'hfe);
    wr(tcpc_pkg::IDX_T2, 8'h00);
    wr(tcpc_pkg::IDX_CTRL_TWO, run);
    repeat (8) @(posedge clk_i);
    wr(tcpc_pkg::IDX_CTRL_TWO, 8'h00);
    rdc(tcpc_pkg::IDX_T2, e);
  endtask

  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    $display("Error at %0t: watchdog expired", $time);
    finish_test();
  end

  // main sequence
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(tcpc_pkg::IDX_CTRL_TWO, 8'h00);
    wr(tcpc_pkg::IDX_CTRL_TWO, 8'hff);
    rdc(tcpc_pkg::IDX_CTRL_TWO, 8'h3f);
    rdc(6'h3f, 8'h00);
    $display("test registers done");
    // pin steering over enable, direction and levels
    for (int k = 0; k < 4; k++)
    begin
      wr(tcpc_pkg::IDX_CTRL_TWO, {2'b00, k[1], k[1], 4'h0});
      dir1 <= k[0];
      dir2 <= ~k[0];
      pwm1 <= k[0];
      pwm2 <= ~k[0];
      pd1 <= ~k[0];
      pd2 <= k[0];
      repeat (3) @(posedge clk_i);
      `CHK(p1oe, k[1] | ~k[0])
      `CHK(p2oe, k[1] | k[0])
      if (k[1])
      begin
        `CHK(p1, k[0])
        `CHK(p2, ~k[0])
      end
      else
      begin
        if (!k[0]) `CHK(p1, 1'b1)
        if (k[0]) `CHK(p2, 1'b1)
      end
    end
    $display("test pins done");
    // timer three stops and runs
    wr(tcpc_pkg::IDX_CTRL_TWO, 8'h00);
    wr(tcpc_pkg::IDX_T3_LO, 8'h34);
    wr(tcpc_pkg::IDX_T3_HI, 8'h12);
    repeat (20) @(posedge clk_i);
    rdc(tcpc_pkg::IDX_T3_LO, 8'h34);
    wr(tcpc_pkg::IDX_CTRL_TWO, 8'h04);
    repeat (10) @(posedge clk_i);
    wr(tcpc_pkg::IDX_CTRL_TWO, 8'h00);
    wb_xfer(1'b0, tcpc_pkg::IDX_T3_LO, 8'h00, rd);
    `CHK(rd[7:0] !== 8'h34, 1'b1)
    wr(tcpc_pkg::IDX_T3_LO, 8'h34);
    $display("test timer three done");
    // capture two: load, overflow, hold, release
    pulse(1'b1);
    rdc(tcpc_pkg::IDX_CAP2_LO, 8'h34);
    rdc(tcpc_pkg::IDX_CAP2_HI, 8'h12);
    wr(tcpc_pkg::IDX_T3_LO, 8'h56);
    pulse(1'b1);
    wr(tcpc_pkg::IDX_T3_LO, 8'h78);
    pulse(1'b1);
    rdc(tcpc_pkg::IDX_CTRL_TWO, 8'h80);
    rdc(tcpc_pkg::IDX_CAP2_LO, 8'h56);
    wr(tcpc_pkg::IDX_T3_LO, 8'h9a);
    pulse(1'b1);
    rdc(tcpc_pkg::IDX_CAP2_HI, 8'h12);
    rdc(tcpc_pkg::IDX_CAP2_LO, 8'h56);
    rdc(tcpc_pkg::IDX_CTRL_TWO, 8'h00);
    pulse(1'b1);
    rdc(tcpc_pkg::IDX_CAP2_LO, 8'h9a);
    rdc(tcpc_pkg::IDX_CAP2_HI, 8'h12);
    $display("test capture two done");
    // capture one only in capture mode of the shared pair
    pulse(1'b0);
    rdc(tcpc_pkg::IDX_SHARED_LO, 8'hff);
    wr(tcpc_pkg::IDX_CTRL_TWO, 8'h08);
    pulse(1'b0);
    rdc(tcpc_pkg::IDX_SHARED_LO, 8'h9a);
    rdc(tcpc_pkg::IDX_SHARED_HI, 8'h12);
    wr(tcpc_pkg::IDX_T3_LO, 8'h11);
    pulse(1'b0);
    wr(tcpc_pkg::IDX_T3_LO, 8'h22);
    pulse(1'b0);
    rdc(tcpc_pkg::IDX_CTRL_TWO, 8'h48);
    rdc(tcpc_pkg::IDX_SHARED_LO, 8'h11);
    $display("test capture one done");
    // interrupt raised, cleared by read, then masked
    wr(tcpc_pkg::IDX_IRQ_MASK, 8'h02);
    wb_xfer(1'b0, tcpc_pkg::IDX_IRQ_STAT, 8'h00, rd);
    repeat (2) @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    pulse(1'b1);
    `CHK(irq_o, 1'b1)
    rdc(tcpc_pkg::IDX_IRQ_STAT, 8'h02);
    repeat (2) @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    wr(tcpc_pkg::IDX_IRQ_MASK, 8'h00);
    pulse(1'b1);
    `CHK(irq_o, 1'b0)
    $display("test interrupt done");
    // timer one and two, chained and apart
    tmr(1'b1, 8'h03, 8'h01);
    tmr(1'b1, 8'h01, 8'h00);
    tmr(1'b1, 8'h02, 8'h00);
    tmr(1'b0, 8'h01, 8'h00);
    $display("test timers done");
    // timer three wraps at the shared pair while it serves as period
    wr(tcpc_pkg::IDX_CTRL_TWO, 8'h00);
    wr(tcpc_pkg::IDX_SHARED_LO, 8'h03);
    wr(tcpc_pkg::IDX_SHARED_HI, 8'h00);
    wr(tcpc_pkg::IDX_T3_LO, 8'h00);
    wr(tcpc_pkg::IDX_T3_HI, 8'h00);
    wr(tcpc_pkg::IDX_CTRL_TWO, 8'h04);
    repeat (20) @(posedge clk_i);
    wr(tcpc_pkg::IDX_CTRL_TWO, 8'h00);
    rdc(tcpc_pkg::IDX_T3_HI, 8'h00);
    wb_xfer(1'b0, tcpc_pkg::IDX_T3_LO, 8'h00, rd);
    `CHK(rd[7:0] <= 8'h03, 1'b1)
    $display("test period done");
    finish_test();
  end
endmodule

`default_nettype wire
